// ### rtl/tgm_consts.svh
// Register indices, field positions, reset values and sizes for the transmit gate mute block
`ifndef TGM_CONSTS_SVH
`define TGM_CONSTS_SVH
`define TGM_ADDR_W 12
`define TGM_IDX_W 10
`define TGM_IDX_TX_GATE 10'h03f
`define TGM_IDX_CAL_DIV 10'h050
`define TGM_IDX_STATUS 10'h040
`define TGM_TX_GATE_RESET 8'h00
`define TGM_CAL_DIV_RESET 8'h28
`define TGM_BIT_MUTE_ONE 5
`define TGM_BIT_MUTE_ZERO 4
`define TGM_CAL_DIV_LSB 0
`define TGM_CAL_DIV_MSB 3
`define TGM_BIT_ST_MUTED_ZERO 0
`define TGM_BIT_ST_MUTED_ONE 1
`define TGM_BIT_ST_PIN_ZERO 2
`define TGM_BIT_ST_PIN_ONE 3
`define TGM_SAMPLE_W 16
`endif

// ### rtl/tgm_pkg.sv
// Types shared by the transmit gate mute block
`default_nettype none
package tgm_pkg;
  typedef logic [7:0] tgm_byte_t;
  typedef logic [15:0] tgm_sample_t;
  typedef enum logic [1:0] {
    TGM_REG_NONE = 2'h0,
    TGM_REG_GATE = 2'h1,
    TGM_REG_CAL_DIV = 2'h3,
    TGM_REG_STATUS = 2'h2
  } tgm_reg_t;
endpackage : tgm_pkg
`default_nettype wire

// ### rtl/tgm_top.sv
// Transmit gate mute control: APB register bank and per-converter output muting
`include "tgm_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tgm_top import tgm_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TGM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit gate pins
  input wire logic transmit_gate_pin_zero,
  input wire logic transmit_gate_pin_one,
  // Datapath samples
  input wire logic [`TGM_SAMPLE_W-1:0] converter_zero_in,
  input wire logic [`TGM_SAMPLE_W-1:0] converter_one_in,
  output logic [`TGM_SAMPLE_W-1:0] converter_zero_out,
  output logic [`TGM_SAMPLE_W-1:0] converter_one_out,
  // Calibration divider setting for the calibration engine
  output logic [3:0] cal_clk_div_setting
);

  function automatic tgm_reg_t tgm_decode(input logic [`TGM_ADDR_W-1:0] a);
    tgm_reg_t r;
    r = TGM_REG_NONE;
    if (a == {`TGM_IDX_TX_GATE, 2'b00}) r = TGM_REG_GATE;
    if (a == {`TGM_IDX_CAL_DIV, 2'b00}) r = TGM_REG_CAL_DIV;
    if (a == {`TGM_IDX_STATUS, 2'b00}) r = TGM_REG_STATUS;
    return r;
  endfunction : tgm_decode

  tgm_byte_t transmit_gate_control;
  tgm_byte_t calibration_clock_divider;
  tgm_byte_t status_byte;
  tgm_byte_t read_byte;
  tgm_reg_t access_reg;
  logic setup_phase;
  logic access_phase;
  logic write_strobe;
  logic mute_select_converter_zero;
  logic mute_select_converter_one;
  logic [1:0] gate_pin;
  logic [1:0] mute_select;
  logic [1:0] pin_seen;
  logic [1:0] muted;
  tgm_sample_t din [2];
  tgm_sample_t dout [2];

  // Bus decode; zero wait states, so the access phase always completes
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign access_reg = tgm_decode(paddr);
  assign write_strobe = access_phase & pwrite & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access_phase & (access_reg == TGM_REG_NONE);

  // Only byte lane 0 holds data; other lanes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_gate_control <= `TGM_TX_GATE_RESET;
      calibration_clock_divider <= `TGM_CAL_DIV_RESET;
    end else if (write_strobe) begin
      if (access_reg == TGM_REG_GATE) transmit_gate_control <= pwdata[7:0];
      if (access_reg == TGM_REG_CAL_DIV) calibration_clock_divider <= pwdata[7:0];
    end
  end

  assign mute_select_converter_one = transmit_gate_control[`TGM_BIT_MUTE_ONE];
  assign mute_select_converter_zero = transmit_gate_control[`TGM_BIT_MUTE_ZERO];
  assign cal_clk_div_setting = calibration_clock_divider[`TGM_CAL_DIV_MSB:`TGM_CAL_DIV_LSB];

  assign status_byte = {4'h0, pin_seen[1], pin_seen[0], muted[1], muted[0]};
  assign read_byte = (access_reg == TGM_REG_GATE) ? transmit_gate_control :
                     (access_reg == TGM_REG_CAL_DIV) ? calibration_clock_divider :
                     (access_reg == TGM_REG_STATUS) ? status_byte : 8'h00;

  // Read data captured in setup so it is stable for the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite) prdata <= {24'h00_0000, read_byte};
  end

  assign gate_pin = {transmit_gate_pin_one, transmit_gate_pin_zero};
  assign mute_select = {mute_select_converter_one, mute_select_converter_zero};
  assign din[0] = converter_zero_in;
  assign din[1] = converter_one_in;

  // One register stage per converter; the mute costs no extra latency over the data
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_conv
      logic mute_now;
      tgm_sample_t next_out;
      assign mute_now = mute_select[g] & ~gate_pin[g];
      assign next_out = mute_now ? '0 : din[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dout[g] <= '0;
        end else begin
          dout[g] <= next_out;
        end
      end
    end
  endgenerate

  // Status flags in one process so each vector has a single driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_seen <= 2'b11;
      muted <= 2'b00;
    end else begin
      pin_seen <= gate_pin;
      muted <= mute_select & ~gate_pin;
    end
  end

  assign converter_zero_out = dout[0];
  assign converter_one_out = dout[1];

  default clocking tgm_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mute_one_write_a: assert property (
    write_strobe && access_reg == TGM_REG_GATE |=>
      mute_select_converter_one == $past(pwdata[5]))
    else $error("mute select one not taken from bit 5");

  mute_zero_write_a: assert property (
    write_strobe && access_reg == TGM_REG_GATE |=>
      mute_select_converter_zero == $past(pwdata[4]))
    else $error("mute select zero not taken from bit 4");

  one_muted_a: assert property (
    mute_select_converter_one && !transmit_gate_pin_one |=> converter_one_out == '0)
    else $error("converter one not zeroed with gate low");

  one_passes_a: assert property (
    transmit_gate_pin_one |=> converter_one_out == $past(converter_one_in))
    else $error("converter one not passing with gate high");

  zero_muted_a: assert property (
    mute_select_converter_zero && !transmit_gate_pin_zero |=> converter_zero_out == '0)
    else $error("converter zero not zeroed with gate low");

  zero_passes_a: assert property (
    transmit_gate_pin_zero |=> converter_zero_out == $past(converter_zero_in))
    else $error("converter zero not passing with gate high");

  unselected_normal_a: assert property (
    !mute_select_converter_zero && !mute_select_converter_one |=>
      converter_zero_out == $past(converter_zero_in) &&
      converter_one_out == $past(converter_one_in))
    else $error("output altered without mute selection");

  held_low_zero_a: assert property (
    (mute_select_converter_zero && !transmit_gate_pin_zero)[*2] |->
      converter_zero_out == '0 && muted[0])
    else $error("zero samples missing after gate low sample");

endmodule : tgm_top

`default_nettype wire

// ### tb/tb_tx_gate_mute_control.sv
// Testbench for the transmit gate mute block
`timescale 1ns/1ns
`default_nettype none
module tb_tx_gate_mute_control;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pin_zero, pin_one, want_zero = 1'b1, want_one = 1'b1;
  logic [15:0] out0, out1;
  logic [3:0] div;
  logic [3:0] strb = 4'h1;
  int num_errors = 0, comparisons = 0;
  always #10 pclk = ~pclk;
  tgm_gate_ctl gate_u (.pclk(pclk), .presetn(presetn), .want_zero(want_zero),
    .want_one(want_one), .pin_zero(pin_zero), .pin_one(pin_one));
  tgm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .transmit_gate_pin_zero(pin_zero),
    .transmit_gate_pin_one(pin_one), .converter_zero_in(16'h1234),
    .converter_one_in(16'hbeef), .converter_zero_out(out0), .converter_one_out(out1),
    .cal_clk_div_setting(div));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Entered just after an edge; leaves one idle edge so requests never collide
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic pins(input logic wz, input logic wo, input logic [15:0] e0, e1);
    want_zero <= wz;
    want_one <= wo;
    repeat (3) @(posedge pclk);
    chk(out0, e0);
    chk(out1, e1);
  endtask : pins
  task automatic t_reset;
    xfer(1'b0, 12'h0fc, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h140, 32'h0);
    chk(rd, 32'h28);
    chk(div, 4'h8);
    pins(1'b0, 1'b0, 16'h1234, 16'hbeef);
  endtask : t_reset
  task automatic t_zero;
    xfer(1'b1, 12'h0fc, 32'h10);
    pins(1'b0, 1'b0, 16'h0, 16'hbeef);
    pins(1'b1, 1'b0, 16'h1234, 16'hbeef);
  endtask : t_zero
  task automatic t_one;
    xfer(1'b1, 12'h0fc, 32'h20);
    pins(1'b0, 1'b0, 16'h1234, 16'h0);
    pins(1'b0, 1'b1, 16'h1234, 16'hbeef);
  endtask : t_one
  task automatic t_cal;
    xfer(1'b1, 12'h140, 32'h2a);
    chk(div, 4'ha);
    xfer(1'b1, 12'h200, 32'hff);
    chk(err, 1'b1);
    xfer(1'b0, 12'h0fc, 32'h0);
    chk(rd, 32'h20);
  endtask : t_cal
  // Lane 0 strobe low must leave the register alone; status shows pins and mutes
  task automatic t_strb;
    strb <= 4'h0;
    xfer(1'b1, 12'h0fc, 32'h10);
    strb <= 4'h1;
    xfer(1'b0, 12'h0fc, 32'h0);
    chk(rd, 32'h20);
    xfer(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h08);
  endtask : t_strb
  // Reset in mid-run returns both registers to their defaults
  task automatic t_rst2;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h0fc, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h140, 32'h0);
    chk(rd, 32'h28);
  endtask : t_rst2
  task automatic summarize;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_zero();
    t_one();
    t_cal();
    t_strb();
    t_rst2();
    summarize();
  end
  initial begin
    repeat (2000) @(posedge pclk);
    num_errors++;
    summarize();
  end
endmodule : tb_tx_gate_mute_control
`default_nettype wire

// ### tb/tgm_gate_ctl.sv
// Model of the external controller that drives the two gate pins
`timescale 1ns/1ns
`default_nettype none
module tgm_gate_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requested pin levels
  input wire logic want_zero,
  input wire logic want_one,
  // Gate pins
  output logic pin_zero,
  output logic pin_one
);
  // Pins move just after an edge, so the block never samples a changing level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_zero <= 1'b1;
      pin_one <= 1'b1;
    end else begin
      pin_zero <= want_zero;
      pin_one <= want_one;
    end
  end
endmodule : tgm_gate_ctl
`default_nettype wire
